// file: tmr8_defs.svh
// Purpose: constants of the 8-bit timer/counter with two compare channels
// Assumes: APB register map, 32-bit words, one clock
// Notes: offsets and field positions used by the timer and the testbench
//
// Functional notes
// (R1) timer clock is the io clock, or the oscillator pin when async select set
// (R2) each timer clock clears, increments or decrements the counter per mode
// (R3) clock select zero gives no timer clock; counter stops
// (R4) CPU reads and writes the counter with or without timer clock
// (R5) CPU counter write beats any clear or count in the same cycle
// (R6) three-bit waveform mode: two bits in control A, one in control B
// (R7) overflow flag set per waveform mode and can request an interrupt
// (R8) counter compared with both compare values at all times
// (R9) compare match sets its flag at the next timer clock
// (R10) enabled flag requests interrupt; cleared by acknowledge or writing one
// (R11) compare outputs driven from match, mode, action bits, max and bottom
// (R12) PWM modes double buffer compare values, updated at top or bottom
// (R13) buffered: CPU reaches buffer; otherwise the active compare register
// (R14) force strobe in non-PWM modes acts like a match without flag or clear
// (R15) counter write blocks all matches in the next timer clock; the CTC clear on compare A match is not blocked
// (R16) compare output state kept across waveform mode changes
// (R17) action bits unbuffered; apply from first match after the write
// (R18) nonzero action overrides port value; direction stays with direction bit
// (R19) action zero leaves compare output unchanged at a match
// (R20) software should not write counter equal to compare or bottom downcounting
// (R21) software should set compare output via force before enabling the pin
// (R22) bottom means counter 0x00, max means counter 0xFF
// (R23) normal mode counts up, wraps, overflow flag set as counter hits zero
// (R24) reset clears counter, compares, outputs, flags and control: timer stopped
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

// register byte offsets
`define TMR8_OFS_CTRL_A 8'h00
`define TMR8_OFS_CTRL_B 8'h04
`define TMR8_OFS_COUNT 8'h08
`define TMR8_OFS_CMP_A 8'h0C
`define TMR8_OFS_CMP_B 8'h10
`define TMR8_OFS_FLAGS 8'h14
`define TMR8_OFS_MASK 8'h18
`define TMR8_OFS_ASYNC 8'h1C

// control A fields
`define TMR8_ACT_A_HI 7
`define TMR8_ACT_A_LO 6
`define TMR8_ACT_B_HI 5
`define TMR8_ACT_B_LO 4
`define TMR8_WGM_LO_HI 1
`define TMR8_WGM_LO_LO 0
// control B fields
`define TMR8_FORCE_A 7
`define TMR8_FORCE_B 6
`define TMR8_WGM_HI 3
`define TMR8_CS_HI 2
`define TMR8_CS_LO 0
// flag and mask bits
`define TMR8_BIT_OVF 0
`define TMR8_BIT_CMPA 1
`define TMR8_BIT_CMPB 2
// async register bit
`define TMR8_BIT_ASYNC 0

// waveform modes
`define TMR8_WGM_NORMAL 3'h0
`define TMR8_WGM_PHASE 3'h1
`define TMR8_WGM_CTC 3'h2
`define TMR8_WGM_FAST 3'h3
`define TMR8_WGM_PHASE_A 3'h5
`define TMR8_WGM_FAST_A 3'h7

// counter extremes and reset value
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hFF
`define TMR8_RST_BYTE 8'h00

`endif

// file: tmr8_pkg.sv
// Purpose: types of the 8-bit timer/counter
// Assumes: tmr8_defs.svh holds the numbers
// Notes: the whole module state is one packed struct
package tmr8_pkg;

	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] cnt;
		logic up;
		logic blk;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [2:0] flags;
		logic [2:0] mask;
		logic async_sel;
		logic osc_q;
		logic osc_prev;
		logic oc_a;
		logic oc_b;
		logic pin_a_out;
		logic pin_a_oe;
		logic pin_b_out;
		logic pin_b_oe;
		logic osc_out;
		logic [2:0] irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tmr8_state_t;

endpackage

// file: tmr8_timer.sv
// Purpose: 8-bit timer/counter with two compare channels behind APB
// Assumes: all inputs synchronous to pclk; oscillator pin sampled as data
// Notes: no prescaler, any nonzero clock select gives one tick per source edge
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_timer
	import tmr8_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_in_pin,
	output logic osc_out_pin,
	input wire logic port_a_value,
	input wire logic port_b_value,
	input wire logic compare_pin_direction_bit_a,
	input wire logic compare_pin_direction_bit_b,
	output logic compare_output_a,
	output logic compare_output_a_oe,
	output logic compare_output_b,
	output logic compare_output_b_oe,
	input wire logic [2:0] irq_ack,
	output logic [2:0] irq_req
);

	////////////////////////////////////////////////////////////////////////////
	// helper functions

	// pwm modes use double buffering
	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = (m == `TMR8_WGM_PHASE) || (m == `TMR8_WGM_FAST) ||
			(m == `TMR8_WGM_PHASE_A) || (m == `TMR8_WGM_FAST_A);
	endfunction

	// next compare output state of one channel
	function automatic logic oc_step(input logic [2:0] m, input logic [1:0] act, input logic oc,
		input logic ev, input logic force_s, input logic wrap, input logic up);
		logic r;
		r = oc;
		if (act != 2'h0) begin
			if (!is_pwm(m)) begin
				if (ev || force_s) begin
					r = (act == 2'h1) ? ~oc : act[0];
				end
			end else if ((m == `TMR8_WGM_FAST) || (m == `TMR8_WGM_FAST_A)) begin
				if (ev) begin
					r = (act == 2'h1) ? ~oc : act[0];
				end
				if (wrap && act[1]) begin
					r = ~act[0]; // bottom action wins for a max compare
				end
			end else if (ev) begin
				r = (act == 2'h1) ? ~oc : (up ? act[0] : ~act[0]);
			end
		end
		oc_step = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	tmr8_state_t s_reg;
	tmr8_state_t s_next;
	logic [2:0] mode;
	logic tick;
	logic [7:0] top;
	logic match_a;
	logic match_b;
	logic ev_a;
	logic ev_b;
	logic wrap;
	logic ovf_ev;
	logic wr;
	logic rd;
	logic [1:0] act_a;
	logic [1:0] act_b;

	// decoded fields and timer tick
	always_comb begin
		mode = {s_reg.ctrl_b[`TMR8_WGM_HI], s_reg.ctrl_a[`TMR8_WGM_LO_HI:`TMR8_WGM_LO_LO]}; // R6
		act_a = s_reg.ctrl_a[`TMR8_ACT_A_HI:`TMR8_ACT_A_LO];
		act_b = s_reg.ctrl_a[`TMR8_ACT_B_HI:`TMR8_ACT_B_LO];
		tick = (s_reg.ctrl_b[`TMR8_CS_HI:`TMR8_CS_LO] != 3'h0) && // R3
			(s_reg.async_sel ? (s_reg.osc_q && !s_reg.osc_prev) : 1'b1); // R1
		top = ((mode == `TMR8_WGM_FAST_A) || (mode == `TMR8_WGM_PHASE_A)) ? s_reg.cmp_a : `TMR8_MAX;
		match_a = (s_reg.cnt == s_reg.cmp_a); // R8
		match_b = (s_reg.cnt == s_reg.cmp_b); // R8
		ev_a = tick && match_a && !s_reg.blk; // R15
		ev_b = tick && match_b && !s_reg.blk; // R15
		wrap = tick && ((mode == `TMR8_WGM_FAST) || (mode == `TMR8_WGM_FAST_A)) && (s_reg.cnt == top);
		// overflow event per mode, applied after the clears so that set wins
		ovf_ev = tick && ((!is_pwm(mode) && (s_reg.cnt == `TMR8_MAX)) || wrap || // R7 R23
			(is_pwm(mode) && !wrap && !s_reg.up && (s_reg.cnt == `TMR8_BOTTOM)));
		wr = psel && penable && s_reg.pready && pwrite;
		rd = psel && !penable && !pwrite;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_next = s_reg;
		s_next.osc_q = osc_in_pin;
		s_next.osc_prev = s_reg.osc_q;
		s_next.osc_out = ~s_reg.osc_q;
		s_next.pready = psel && !penable;
		s_next.pslverr = 1'b0;
		// counter step on each tick
		if (tick) begin
			s_next.blk = 1'b0;
			unique case (mode)
				`TMR8_WGM_CTC: begin
					s_next.cnt = match_a ? `TMR8_BOTTOM : s_reg.cnt + 8'h01; // R2
				end
				`TMR8_WGM_FAST, `TMR8_WGM_FAST_A: begin
					s_next.cnt = (s_reg.cnt == top) ? `TMR8_BOTTOM : s_reg.cnt + 8'h01; // R2
				end
				`TMR8_WGM_PHASE, `TMR8_WGM_PHASE_A: begin
					if (s_reg.up) begin
						s_next.up = (s_reg.cnt != top);
						s_next.cnt = (s_reg.cnt == top) ? s_reg.cnt - 8'h01 : s_reg.cnt + 8'h01; // R2
					end else begin
						s_next.up = (s_reg.cnt == `TMR8_BOTTOM); // R22
						s_next.cnt = (s_reg.cnt == `TMR8_BOTTOM) ? s_reg.cnt + 8'h01 : s_reg.cnt - 8'h01;
					end
				end
				default: begin
					s_next.cnt = s_reg.cnt + 8'h01; // R23
					s_next.up = 1'b1;
				end
			endcase
			// overflow flag per mode
			if (ovf_ev) begin
				s_next.flags[`TMR8_BIT_OVF] = 1'b1; // R7 R23
			end
			// active compare reload at top or bottom
			if (wrap || (is_pwm(mode) && s_reg.up && (s_reg.cnt == top))) begin
				s_next.cmp_a = s_reg.buf_a; // R12
				s_next.cmp_b = s_reg.buf_b; // R12
			end
		end
		// compare flags and outputs
		s_next.oc_a = oc_step(mode, act_a, s_reg.oc_a, ev_a, // R11 R16 R17 R19
			wr && (paddr == `TMR8_OFS_CTRL_B) && pwdata[`TMR8_FORCE_A], wrap, s_reg.up); // R14
		s_next.oc_b = oc_step(mode, act_b, s_reg.oc_b, ev_b,
			wr && (paddr == `TMR8_OFS_CTRL_B) && pwdata[`TMR8_FORCE_B], wrap, s_reg.up); // R14
		s_next.flags = s_next.flags & ~irq_ack; // R10
		// register writes
		if (wr) begin
			unique case (paddr)
				`TMR8_OFS_CTRL_A: s_next.ctrl_a = pwdata[7:0] & 8'hF3;
				`TMR8_OFS_CTRL_B: s_next.ctrl_b = pwdata[7:0] & 8'h0F; // strobes never stored
				`TMR8_OFS_COUNT: begin
					s_next.cnt = pwdata[7:0]; // R4 R5
					s_next.blk = 1'b1; // R15
				end
				`TMR8_OFS_CMP_A: begin
					s_next.buf_a = pwdata[7:0]; // R13
					if (!is_pwm(mode)) begin
						s_next.cmp_a = pwdata[7:0]; // R13
					end
				end
				`TMR8_OFS_CMP_B: begin
					s_next.buf_b = pwdata[7:0]; // R13
					if (!is_pwm(mode)) begin
						s_next.cmp_b = pwdata[7:0]; // R13
					end
				end
				`TMR8_OFS_FLAGS: s_next.flags = s_next.flags & ~pwdata[2:0]; // R10
				`TMR8_OFS_MASK: s_next.mask = pwdata[2:0];
				`TMR8_OFS_ASYNC: s_next.async_sel = pwdata[`TMR8_BIT_ASYNC]; // R1
				default: s_next.pslverr = 1'b0;
			endcase
		end
		// hardware set wins over any clear
		if (ev_a) begin
			s_next.flags[`TMR8_BIT_CMPA] = 1'b1; // R9
		end
		if (ev_b) begin
			s_next.flags[`TMR8_BIT_CMPB] = 1'b1; // R9
		end
		if (ovf_ev) begin
			s_next.flags[`TMR8_BIT_OVF] = 1'b1; // R7
		end
		// read data captured in the setup cycle
		if (rd) begin
			unique case (paddr)
				`TMR8_OFS_CTRL_A: s_next.prdata = {24'h000000, s_reg.ctrl_a};
				`TMR8_OFS_CTRL_B: s_next.prdata = {24'h000000, s_reg.ctrl_b};
				`TMR8_OFS_COUNT: s_next.prdata = {24'h000000, s_reg.cnt}; // R4
				`TMR8_OFS_CMP_A: s_next.prdata = {24'h000000, s_reg.buf_a}; // R13
				`TMR8_OFS_CMP_B: s_next.prdata = {24'h000000, s_reg.buf_b}; // R13
				`TMR8_OFS_FLAGS: s_next.prdata = {29'h00000000, s_reg.flags};
				`TMR8_OFS_MASK: s_next.prdata = {29'h00000000, s_reg.mask};
				`TMR8_OFS_ASYNC: s_next.prdata = {31'h00000000, s_reg.async_sel};
				default: s_next.prdata = 32'h00000000;
			endcase
		end
		if (psel && !penable) begin
			s_next.pslverr = (paddr[1:0] != 2'h0) || (paddr > `TMR8_OFS_ASYNC);
		end
		// interrupt requests and pin override
		s_next.irq = s_next.flags & s_next.mask; // R10
		s_next.pin_a_out = (s_next.ctrl_a[`TMR8_ACT_A_HI:`TMR8_ACT_A_LO] != 2'h0) ? s_next.oc_a : port_a_value; // R18
		s_next.pin_b_out = (s_next.ctrl_a[`TMR8_ACT_B_HI:`TMR8_ACT_B_LO] != 2'h0) ? s_next.oc_b : port_b_value; // R18
		s_next.pin_a_oe = compare_pin_direction_bit_a; // R18
		s_next.pin_b_oe = compare_pin_direction_bit_b; // R18
	end

	// state register, all zero at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0; // R24
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign osc_out_pin = s_reg.osc_out;
	assign compare_output_a = s_reg.pin_a_out;
	assign compare_output_a_oe = s_reg.pin_a_oe;
	assign compare_output_b = s_reg.pin_b_out;
	assign compare_output_b_oe = s_reg.pin_b_oe;
	assign irq_req = s_reg.irq;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic cnt_wr;
	assign cnt_wr = wr && (paddr == `TMR8_OFS_COUNT);

	a_stop_holds: assert property ((s_reg.ctrl_b[2:0] == 3'h0) && !cnt_wr |=> $stable(s_reg.cnt)) // R3
		else $error("counter moved while stopped");
	a_write_wins: assert property (cnt_wr && tick |=> s_reg.cnt == $past(pwdata[7:0])) // R5
		else $error("counter write lost to count");
	a_flag_a_set: assert property (ev_a |=> s_reg.flags[`TMR8_BIT_CMPA]) // R9
		else $error("compare flag a not set");
	a_block_match: assert property (s_reg.blk && tick && !s_reg.flags[`TMR8_BIT_CMPB] |=> // R15
		!s_reg.flags[`TMR8_BIT_CMPB]) else $error("blocked match set flag b");
	a_normal_ovf: assert property ((mode == `TMR8_WGM_NORMAL) && tick && !cnt_wr && // R23
		(s_reg.cnt == `TMR8_MAX) |=> (s_reg.cnt == 8'h00) && s_reg.flags[`TMR8_BIT_OVF])
		else $error("normal overflow wrong");
	a_ctc_clear: assert property ((mode == `TMR8_WGM_CTC) && tick && match_a && !cnt_wr |=> // R2
		s_reg.cnt == 8'h00) else $error("ctc did not clear");
	a_force_toggle: assert property (!is_pwm(mode) && (act_a == 2'h1) && !ev_a && wr && // R14
		(paddr == `TMR8_OFS_CTRL_B) && pwdata[`TMR8_FORCE_A] |=> (s_reg.oc_a != $past(s_reg.oc_a)))
		else $error("force did not toggle output a");
	a_act_zero: assert property ((act_b == 2'h0) |=> s_reg.oc_b == $past(s_reg.oc_b)) // R19
		else $error("output b changed with no action");
	a_override: assert property ((act_a != 2'h0) && $stable(s_reg.ctrl_a) |-> compare_output_a == s_reg.oc_a) // R18
		else $error("pin a not overridden");
	a_irq_req: assert property (s_reg.flags[`TMR8_BIT_CMPA] && s_reg.mask[`TMR8_BIT_CMPA] |-> // R10
		irq_req[`TMR8_BIT_CMPA]) else $error("interrupt a missing");

	c_overflow: cover property (tick && s_reg.flags == 3'h0 ##1 s_reg.flags[`TMR8_BIT_OVF]);
	c_match_a: cover property (ev_a ##1 irq_req[`TMR8_BIT_CMPA]);
	c_reload: cover property (wrap && (s_reg.buf_a != s_reg.cmp_a));
	c_async: cover property (s_reg.async_sel && tick);

endmodule
`default_nettype wire

// file: tmr8_timer_tb_top.sv
// Purpose: self-checking bench of the 8-bit timer over APB
// Assumes: zero-wait APB slave, one tick per pclk while clock select is 1 and async select is clear
// Notes: counter is stopped before every counter read so values are exact
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_timer_tb_top;

	logic pclk, presetn, psel, penable, pwrite, osc, port_a, port_b, dir_a, dir_b;
	logic pready, pslverr, osc_out, oc_a, oe_a, oc_b, oe_b, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] irq_ack, irq_req;
	int mismatches, checks_done;

	tmr8_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_in_pin(osc), .osc_out_pin(osc_out), .port_a_value(port_a), .port_b_value(port_b),
		.compare_pin_direction_bit_a(dir_a), .compare_pin_direction_bit_b(dir_b),
		.compare_output_a(oc_a), .compare_output_a_oe(oe_a), .compare_output_b(oc_b),
		.compare_output_b_oe(oe_b), .irq_ack(irq_ack), .irq_req(irq_req));

	////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		#50000;
		mismatches++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	// verdict, compare and bus tasks
	task results;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// setup, then hold the access phase until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// run for exactly three ticks: start, then stop
	task spin;
		wr(`TMR8_OFS_CTRL_B, 32'h1);
		wr(`TMR8_OFS_CTRL_B, 32'h0);
	endtask

	task wait_pin;
		repeat (3) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		osc = 1'b0;
		port_a = 1'b1;
		port_b = 1'b0;
		dir_a = 1'b1;
		dir_b = 1'b0;
		irq_ack = 3'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rdc("reset_reg", 8'(i * 4), 32'h0);
		end
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		// counter and compare path, timer stopped
		wr(`TMR8_OFS_MASK, 32'h7);
		wr(`TMR8_OFS_CMP_A, 32'h20);
		rdc("cmp_direct", `TMR8_OFS_CMP_A, 32'h20);
		wr(`TMR8_OFS_COUNT, 32'h20);
		repeat (5) @(posedge pclk);
		rdc("stopped_cnt", `TMR8_OFS_COUNT, 32'h20);
		spin();
		rdc("blocked_flag", `TMR8_OFS_FLAGS, 32'h0);
		rdc("count_seq", `TMR8_OFS_COUNT, 32'h23);
		wr(`TMR8_OFS_COUNT, 32'h1F);
		spin();
		rdc("match_flag", `TMR8_OFS_FLAGS, 32'h2);
		chk("irq_cmp", 32'h2, {29'h0, irq_req});
		wr(`TMR8_OFS_FLAGS, 32'h2);
		rdc("flag_w1c", `TMR8_OFS_FLAGS, 32'h0);
		// counter write while running
		wr(`TMR8_OFS_CTRL_B, 32'h1);
		wr(`TMR8_OFS_COUNT, 32'h80);
		wr(`TMR8_OFS_CTRL_B, 32'h0);
		apb(1'b0, `TMR8_OFS_COUNT, 32'h0);
		chk("cpu_wins", 32'h1, {31'h0, rd >= 32'h80 && rd < 32'h88});
		// wrap to zero: overflow, then match of compare b at bottom
		wr(`TMR8_OFS_COUNT, 32'hFE);
		spin();
		rdc("ovf_flag", `TMR8_OFS_FLAGS, 32'h5);
		chk("irq_ovf", 32'h5, {29'h0, irq_req});
		@(posedge pclk);
		irq_ack <= 3'h1;
		@(posedge pclk);
		irq_ack <= 3'h0;
		rdc("ack_clear", `TMR8_OFS_FLAGS, 32'h4);
		wr(`TMR8_OFS_FLAGS, 32'h4);
		// compare output, force strobe and port override
		wait_pin();
		chk("port_pass", 32'h1, {31'h0, oc_a});
		chk("dir_a", 32'h1, {31'h0, oe_a});
		wr(`TMR8_OFS_CTRL_A, 32'h40);
		wait_pin();
		chk("override_a", 32'h0, {31'h0, oc_a});
		wr(`TMR8_OFS_CTRL_B, 32'h80);
		wait_pin();
		chk("force_a", 32'h1, {31'h0, oc_a});
		rdc("force_noflag", `TMR8_OFS_FLAGS, 32'h0);
		wr(`TMR8_OFS_CTRL_A, 32'h0);
		wr(`TMR8_OFS_CTRL_B, 32'h80);
		wr(`TMR8_OFS_CTRL_A, 32'h40);
		wait_pin();
		chk("idle_action", 32'h1, {31'h0, oc_a});
		wr(`TMR8_OFS_CTRL_A, 32'h43);
		wr(`TMR8_OFS_CTRL_B, 32'h80);
		wait_pin();
		chk("pwm_keep", 32'h1, {31'h0, oc_a});
		wr(`TMR8_OFS_CTRL_A, 32'h30);
		wr(`TMR8_OFS_CTRL_B, 32'h40);
		wait_pin();
		chk("force_b", 32'h1, {31'h0, oc_b});
		chk("dir_b_off", 32'h0, {31'h0, oe_b});
		dir_b <= 1'b1;
		wait_pin();
		chk("dir_b_on", 32'h1, {31'h0, oe_b});
		// oscillator as tick source: three rising edges
		wr(`TMR8_OFS_COUNT, 32'h0);
		wr(`TMR8_OFS_ASYNC, 32'h1);
		wr(`TMR8_OFS_CTRL_B, 32'h1);
		repeat (3) begin
			repeat (4) @(posedge pclk);
			osc <= 1'b1;
			repeat (4) @(posedge pclk);
			osc <= 1'b0;
		end
		repeat (4) @(posedge pclk);
		wr(`TMR8_OFS_CTRL_B, 32'h0);
		rdc("async_ticks", `TMR8_OFS_COUNT, 32'h3);
		// clear on compare: blocked tick at 0, clear at match 1, then 0 to 1
		wr(`TMR8_OFS_ASYNC, 32'h0);
		wr(`TMR8_OFS_CTRL_A, 32'h02);
		wr(`TMR8_OFS_CMP_A, 32'h01);
		wr(`TMR8_OFS_COUNT, 32'h0);
		spin();
		rdc("ctc_count", `TMR8_OFS_COUNT, 32'h1);
		rdc("ctc_flags", `TMR8_OFS_FLAGS, 32'h6);
		results();
	end

endmodule

`default_nettype wire
